// [uart_line_status_flags.v]
`timescale 1ns/1ps
`include "uart_lsf_defs.vh"
// What this block does
// - fifo mode: error summary set if any errored
// - summary clears on read when no later errors
// - fifo mode: idle when shifter and fifo empty
// - no fifo: idle when holding and shifter empty
// - normal mode: hold-empty set after last load
// - hold-empty raises interrupt when enabled
// - prog mode: flag means full, irq by threshold
// - uart mode: break after line low one frame
// - infrared: break after pulsed low one frame
// - break yields exactly one all-zero character
// - fifo mode: break shown when char at head
// - break clears on status read; immediate otherwise
// - framing error on missing stop bit
// - framing error also set on break
// - framing error clears on status read
module uart_line_status_flags (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        cyc_i,
  input  wire        stb_i,
  input  wire        we_i,
  input  wire [7:0]  adr_i,
  input  wire [3:0]  sel_i,
  input  wire [31:0] dat_i,
  output reg  [31:0] dat_o,
  output reg         ack_o,
  input  wire        sin_i,
  input  wire        sir_in_i,
  input  wire        tx_load_i,
  input  wire        tx_shift_empty_i,
  output reg  [7:0]  tx_data_o,
  output reg         tx_wr_o,
  output reg         thre_irq_o
);

  //////////////////////////////////////////////////////////////////////////
  // declarations
  reg  [7:0]  irq_enable_reg;
  reg  [7:0]  fifo_control_reg;
  reg  [7:0]  line_ctrl;
  reg  [15:0] divisor;
  reg  [15:0] div_cnt;
  reg         tick;
  reg  [1:0]  sin_sync;
  reg  [1:0]  sir_sync;
  reg  [3:0]  ir_stretch;
  reg  [7:0]  low_cnt;
  reg  [10:0] rx_mem [0:15];
  reg  [3:0]  rd_ptr;
  reg  [3:0]  wr_ptr;
  reg  [4:0]  rx_count;
  reg  [4:0]  err_count;
  reg         head_new;
  reg         pend_valid;
  reg  [4:0]  tx_count;
  reg         break_flag;
  reg         framing_error_flag;
  reg         rx_err_sum;
  reg  [31:0] rd_val;

  wire        req      = cyc_i & stb_i & ~ack_o;
  wire        wr_req   = req & we_i & sel_i[0];
  wire        rd_req   = req & ~we_i;
  wire        fifo_en  = fifo_control_reg[`FCR_FIFO_EN];
  wire        prog_mode = irq_enable_reg[`IER_PROG_THRE] & fifo_en;
  wire        lsr_read = rd_req & (adr_i == `ADR_LINE_STATUS);
  wire        pop      = rd_req & (adr_i == `ADR_RX_DATA) &
                         (rx_count != 5'h00);
  wire        thr_wr   = wr_req & (adr_i == `ADR_RX_DATA);
  wire        fcr_wr   = wr_req & (adr_i == `ADR_FIFO_CONTROL);
  wire        rx_clr   = fcr_wr & dat_i[`FCR_RX_RESET];
  wire        tx_clr   = fcr_wr & dat_i[`FCR_TX_RESET];
  wire [4:0]  tx_depth = fifo_en ? `FIFO_DEPTH : 5'h01;
  wire        ir_mode  = line_ctrl[`LCR_IR_MODE];
  wire        rx_line  = ir_mode ? (ir_stretch == 4'h0) : sin_sync[1];

  //////////////////////////////////////////////////////////////////////////
  // wishbone slave: one wait state, ack drops the cycle after it rose
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o            <= 1'b0;
      dat_o            <= 32'h00000000;
      irq_enable_reg   <= `IER_RESET;
      fifo_control_reg <= `FCR_RESET;
      line_ctrl        <= `LCR_RESET;
      divisor          <= `DIV_RESET;
    end else begin
      ack_o <= req;
      if (rd_req) begin
        dat_o <= rd_val; // captured before any read side effect lands
      end
      if (wr_req) begin
        case (adr_i)
          `ADR_IRQ_ENABLE:   irq_enable_reg <= dat_i[7:0];
          `ADR_FIFO_CONTROL: fifo_control_reg <= dat_i[7:0] & 8'hf9;
          `ADR_LINE_CONTROL: line_ctrl <= dat_i[7:0];
          `ADR_DIVISOR:      divisor[7:0] <= dat_i[7:0];
          default: ;
        endcase
      end
      if (req & we_i & sel_i[1] & (adr_i == `ADR_DIVISOR)) begin
        divisor[15:8] <= dat_i[15:8];
      end
    end
  end

  // read mux; unmapped addresses read as zero
  always @* begin
    rd_val = 32'h00000000;
    case (adr_i)
      `ADR_RX_DATA:      rd_val = {24'h000000, rx_mem[rd_ptr][7:0]};
      `ADR_IRQ_ENABLE:   rd_val = {24'h000000, irq_enable_reg};
      `ADR_FIFO_CONTROL: rd_val = {24'h000000, fifo_control_reg};
      `ADR_LINE_CONTROL: rd_val = {24'h000000, line_ctrl};
      `ADR_DIVISOR:      rd_val = {16'h0000, divisor};
      `ADR_LINE_STATUS:  rd_val = {24'h000000,
                                   rx_err_sum & fifo_en,
                                   (tx_count == 5'h00) &
                                     tx_shift_empty_i,
                                   prog_mode ? (tx_count == tx_depth)
                                             : (tx_count == 5'h00),
                                   break_flag,
                                   framing_error_flag,
                                   3'b000};
      `ADR_RX_LEVEL:     rd_val = {27'h0000000, rx_count};
      default:           rd_val = 32'h00000000;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // oversampling divider: sixteen ticks per bit, divisor 0 acts as 1
  always @(posedge clk_i) begin
    if (rst_i) begin
      div_cnt <= 16'h0000;
      tick    <= 1'b0;
    end else if (div_cnt + 16'h0001 >= divisor) begin
      div_cnt <= 16'h0000;
      tick    <= 1'b1;
    end else begin
      div_cnt <= div_cnt + 16'h0001;
      tick    <= 1'b0;
    end
  end

  // line inputs come from pins: two flops before anything looks at them
  always @(posedge clk_i) begin
    if (rst_i) begin
      sin_sync <= 2'b11;
      sir_sync <= 2'b11;
    end else begin
      sin_sync <= {sin_sync[0], sin_i};
      sir_sync <= {sir_sync[0], sir_in_i};
    end
  end

  // infrared: each short low pulse reads as one low bit time, so a
  // steady pulse train looks like a held-low line
  always @(posedge clk_i) begin
    if (rst_i) begin
      ir_stretch <= 4'h0;
    end else if (!sir_sync[1]) begin
      ir_stretch <= 4'hf;
    end else if (tick && ir_stretch != 4'h0) begin
      ir_stretch <= ir_stretch - 4'h1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // receiver and break timing
  wire       rx_valid;
  wire [7:0] rx_data;
  wire       rx_pe;
  wire       rx_fe;

  uart_rx_frame u_rx (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .tick_i      (tick),
    .line_i      (rx_line),
    .wlen_i      (line_ctrl[`LCR_WLEN_HI:`LCR_WLEN_LO]),
    .par_en_i    (line_ctrl[`LCR_PAR_EN]),
    .par_even_i  (line_ctrl[`LCR_PAR_EVEN]),
    .valid_o     (rx_valid),
    .data_o      (rx_data),
    .par_err_o   (rx_pe),
    .frame_err_o (rx_fe)
  );

  // frame length in ticks: start + data + parity + stop bits
  wire [3:0] frame_bits = 4'h6 + {2'b00, line_ctrl[`LCR_WLEN_HI:0]} +
                          {3'b000, line_ctrl[`LCR_PAR_EN]} +
                          {3'b000, line_ctrl[`LCR_TWO_STOP]} + 4'h1;
  wire [7:0] frame_ticks = {frame_bits, 4'h0};
  wire       brk_det = (low_cnt > frame_ticks);

  // low-time counter, saturating so a long break cannot wrap
  always @(posedge clk_i) begin
    if (rst_i || rx_line) begin
      low_cnt <= 8'h00;
    end else if (tick && low_cnt != 8'hff) begin
      low_cnt <= low_cnt + 8'h01;
    end
  end

  // an all-zero char with a bad stop is held until the line rises
  // (plain framing error) or the low time passes a frame (break)
  reg  [10:0] pend_entry;
  wire        zero_fe = rx_valid & rx_fe & (rx_data == 8'h00);
  wire        push    = (rx_valid & ~zero_fe) |
                        (pend_valid & (brk_det | rx_line));
  wire [10:0] push_entry = (rx_valid & ~zero_fe) ?
                           {1'b0, rx_fe, rx_pe, rx_data} :
                           {brk_det, 1'b1, pend_entry[8:0]};
  wire        push_err = |push_entry[10:8];
  wire        full     = fifo_en & (rx_count == `FIFO_DEPTH);
  wire        do_push  = push & ~full;

  always @(posedge clk_i) begin
    if (rst_i) begin
      pend_valid <= 1'b0;
      pend_entry <= 11'h000;
    end else if (zero_fe) begin
      pend_valid <= 1'b1;
      pend_entry <= {1'b0, 1'b1, rx_pe, 8'h00};
    end else if (push) begin
      pend_valid <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // receive store: data with its parity, framing and break bits; depth
  // one when fifos are off, a new char then overwrites the old
  always @(posedge clk_i) begin
    if (do_push) begin
      rx_mem[fifo_en ? wr_ptr : rd_ptr] <= push_entry;
    end
  end

  // an empty store has no head; stale or unwritten slots must not count
  wire head_err = (rx_count != 5'h00) & (|rx_mem[rd_ptr][10:8]);

  always @(posedge clk_i) begin
    if (rst_i || rx_clr) begin
      rd_ptr    <= 4'h0;
      wr_ptr    <= 4'h0;
      rx_count  <= 5'h00;
      err_count <= 5'h00;
      head_new  <= 1'b0;
    end else if (!fifo_en) begin
      head_new <= do_push;
      wr_ptr   <= rd_ptr;
      if (do_push) begin
        rx_count  <= 5'h01;
        err_count <= {4'h0, push_err};
      end else if (pop) begin
        rx_count  <= 5'h00;
        err_count <= 5'h00;
      end
    end else begin
      // a new char reaches the head on a push into empty or a pop
      // that leaves something behind
      head_new <= (do_push & (rx_count == 5'h00 ||
                              (pop && rx_count == 5'h01))) |
                  (pop & (rx_count > 5'h01));
      if (do_push) begin
        wr_ptr <= wr_ptr + 4'h1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 4'h1;
      end
      rx_count  <= rx_count + {4'h0, do_push} - {4'h0, pop};
      err_count <= err_count + {4'h0, do_push & push_err}
                             - {4'h0, pop & head_err};
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // sticky status bits; a set in the clearing cycle wins
  wire lsr_clr_ok = (err_count - {4'h0, head_err}) == 5'h00;

  always @(posedge clk_i) begin
    if (rst_i) begin
      break_flag         <= 1'b0;
      framing_error_flag <= 1'b0;
      rx_err_sum         <= 1'b0;
    end else begin
      if (lsr_read) begin
        break_flag         <= 1'b0;
        framing_error_flag <= 1'b0;
      end
      if (lsr_read && lsr_clr_ok) begin
        rx_err_sum <= 1'b0;
      end
      if (head_new && rx_count != 5'h00) begin
        if (rx_mem[rd_ptr][10]) begin
          break_flag <= 1'b1;
        end
        if (rx_mem[rd_ptr][9] | rx_mem[rd_ptr][10]) begin
          framing_error_flag <= 1'b1;
        end
      end
      if (do_push && push_err) begin
        rx_err_sum <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // transmit side: count of words waiting in holding reg or tx fifo;
  // the storage lives outside, this block only sees writes and loads
  wire tx_accept = thr_wr & (tx_count < tx_depth);
  wire tx_take   = tx_load_i & (tx_count != 5'h00);
  reg  [4:0] tx_thresh;

  always @(posedge clk_i) begin
    if (rst_i || tx_clr) begin
      tx_count <= 5'h00;
    end else begin
      tx_count <= tx_count + {4'h0, tx_accept} - {4'h0, tx_take};
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      tx_wr_o   <= 1'b0;
      tx_data_o <= 8'h00;
    end else begin
      tx_wr_o <= tx_accept; // a write to a full holding path is dropped
      if (tx_accept) begin
        tx_data_o <= dat_i[7:0];
      end
    end
  end

  // threshold for programmable mode: empty, two, quarter, half
  always @* begin
    case (fifo_control_reg[`FCR_TX_THR_HI:`FCR_TX_THR_LO])
      2'b01:   tx_thresh = `THR_LEVEL_TWO;
      2'b10:   tx_thresh = `THR_LEVEL_QTR;
      2'b11:   tx_thresh = `THR_LEVEL_HALF;
      default: tx_thresh = 5'h00;
    endcase
  end

  // interrupt follows the empty flag, or the threshold in prog mode
  always @(posedge clk_i) begin
    if (rst_i) begin
      thre_irq_o <= 1'b0;
    end else if (prog_mode) begin
      thre_irq_o <= irq_enable_reg[`IER_TX_EMPTY_EN] &
                    (tx_count <= tx_thresh);
    end else begin
      thre_irq_o <= irq_enable_reg[`IER_TX_EMPTY_EN] &
                    (tx_count == 5'h00);
    end
  end

endmodule // uart_line_status_flags

// [uart_lsf_defs.vh]
`ifndef UART_LSF_DEFS_VH
`define UART_LSF_DEFS_VH

// register byte addresses
`define ADR_RX_DATA      8'h00
`define ADR_IRQ_ENABLE   8'h04
`define ADR_FIFO_CONTROL 8'h08
`define ADR_LINE_CONTROL 8'h0c
`define ADR_DIVISOR      8'h10
`define ADR_LINE_STATUS  8'h14
`define ADR_RX_LEVEL     8'h18

// irq_enable_reg fields
`define IER_TX_EMPTY_EN  1
`define IER_PROG_THRE    7
// fifo_control_reg fields
`define FCR_FIFO_EN      0
`define FCR_RX_RESET     1
`define FCR_TX_RESET     2
`define FCR_TX_THR_LO    4
`define FCR_TX_THR_HI    5
// line control fields
`define LCR_WLEN_LO      0
`define LCR_WLEN_HI      1
`define LCR_TWO_STOP     2
`define LCR_PAR_EN       3
`define LCR_PAR_EVEN     4
`define LCR_IR_MODE      6
// line_status_reg fields
`define LSR_FRAME_ERR    3
`define LSR_BREAK        4
`define LSR_HOLD_EMPTY   5
`define LSR_TX_IDLE      6
`define LSR_RX_FIFO_ERR  7

// reset values
`define IER_RESET        8'h00
`define FCR_RESET        8'h00
`define LCR_RESET        8'h03
`define DIV_RESET        16'h0001

// sizes and counts
`define FIFO_DEPTH       5'h10
`define TICKS_PER_BIT    5'h10
`define THR_LEVEL_TWO    5'h02
`define THR_LEVEL_QTR    5'h04
`define THR_LEVEL_HALF   5'h08

`endif

// [uart_rx_frame.v]
`timescale 1ns/1ps
module uart_rx_frame (
  input  wire       clk_i,
  input  wire       rst_i,
  input  wire       tick_i,
  input  wire       line_i,
  input  wire [1:0] wlen_i,
  input  wire       par_en_i,
  input  wire       par_even_i,
  output reg        valid_o,
  output reg  [7:0] data_o,
  output reg        par_err_o,
  output reg        frame_err_o
);

  localparam S_IDLE  = 6'b000001;
  localparam S_START = 6'b000010;
  localparam S_DATA  = 6'b000100;
  localparam S_PAR   = 6'b001000;
  localparam S_STOP  = 6'b010000;
  localparam S_HOLD  = 6'b100000;

  reg [5:0] state;
  reg [3:0] tcnt;
  reg [2:0] bit_idx;
  reg       par_acc;
  wire      mid_start = (tcnt == 4'h7);
  wire      mid_bit   = (tcnt == 4'hf);
  wire [2:0] last_bit = {1'b1, wlen_i};

  //////////////////////////////////////////////////////////////////////////
  // frame state machine, one step per oversampling tick
  always @(posedge clk_i) begin
    valid_o <= 1'b0;
    if (rst_i) begin
      state       <= S_IDLE;
      tcnt        <= 4'h0;
      bit_idx     <= 3'h0;
      par_acc     <= 1'b0;
      data_o      <= 8'h00;
      par_err_o   <= 1'b0;
      frame_err_o <= 1'b0;
    end else if (tick_i) begin
      tcnt <= tcnt + 4'h1;
      case (state)
        S_IDLE: begin
          tcnt <= 4'h0;
          if (!line_i) begin
            state <= S_START;
          end
        end
        S_START: begin
          // a glitch shorter than half a bit is not a start
          if (mid_start) begin
            tcnt    <= 4'h0;
            bit_idx <= 3'h0;
            data_o  <= 8'h00;
            par_acc <= par_even_i ? 1'b0 : 1'b1;
            state   <= line_i ? S_IDLE : S_DATA;
          end
        end
        S_DATA: begin
          if (mid_bit) begin
            data_o[bit_idx] <= line_i;
            par_acc         <= par_acc ^ line_i;
            bit_idx         <= bit_idx + 3'h1;
            if (bit_idx == last_bit) begin
              state <= par_en_i ? S_PAR : S_STOP;
            end
          end
        end
        S_PAR: begin
          if (mid_bit) begin
            par_err_o <= par_acc ^ line_i;
            state     <= S_STOP;
          end
        end
        S_STOP: begin
          if (mid_bit) begin
            if (!par_en_i) begin
              par_err_o <= 1'b0;
            end
            frame_err_o <= ~line_i;
            valid_o     <= 1'b1;
            // after a bad stop wait for the line to rise so a held-low
            // line yields one character only
            state       <= line_i ? S_IDLE : S_HOLD;
          end
        end
        S_HOLD: begin
          if (line_i) begin
            state <= S_IDLE;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

endmodule // uart_rx_frame

// [uart_lsf_asserts.sv]
`timescale 1ns/1ps
`include "uart_lsf_defs.vh"
module uart_lsf_asserts (
  input wire        clk_i,
  input wire        rst_i,
  input wire        cyc_i,
  input wire        stb_i,
  input wire        we_i,
  input wire [7:0]  adr_i,
  input wire [3:0]  sel_i,
  input wire [31:0] dat_i,
  input wire [31:0] dat_o,
  input wire        ack_o,
  input wire        sin_i,
  input wire        sir_in_i,
  input wire        tx_load_i,
  input wire        tx_shift_empty_i,
  input wire [7:0]  tx_data_o,
  input wire        tx_wr_o,
  input wire        thre_irq_o
);
  reg ier1;
  reg ier7;
  reg fcr0;

  // shadow enables, taken at the accepting edge like the real registers
  always @(posedge clk_i) begin
    if (rst_i) begin
      ier1 <= 1'b0;
      ier7 <= 1'b0;
      fcr0 <= 1'b0;
    end else if (cyc_i && stb_i && we_i && !ack_o && sel_i[0]) begin
      if (adr_i == `ADR_IRQ_ENABLE) begin
        ier1 <= dat_i[1];
        ier7 <= dat_i[7];
      end
      if (adr_i == `ADR_FIFO_CONTROL) fcr0 <= dat_i[0];
    end
  end

  ////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // answer to a status read
  sequence lsr_ans;
    ack_o && $past(cyc_i && stb_i && !we_i && adr_i == `ADR_LINE_STATUS);
  endsequence
  // no line activity and no pop that could bring a new head
  sequence quiet;
    sin_i && sir_in_i && !(stb_i && adr_i == `ADR_RX_DATA);
  endsequence

  AST_ACK_ONE: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not answered one cycle later");
  AST_ACK_PULSE: assert property (ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");
  AST_TXWR: assert property (tx_wr_o |-> ack_o &&
    tx_data_o == $past(dat_i[7:0]) &&
    $past(we_i && stb_i && adr_i == `ADR_RX_DATA))
    else $error("transmit strobe without matching write");
  AST_IDLE_BUSY: assert property (
    lsr_ans ##0 $past(!tx_shift_empty_i) |-> !dat_o[6])
    else $error("idle shown while shifter busy");
  AST_BRK_FE: assert property (lsr_ans ##0 dat_o[4] |-> dat_o[3])
    else $error("break shown without framing error");
  AST_BRK_CLR: assert property (
    lsr_ans ##0 dat_o[4] ##1 quiet [*2] ##1 lsr_ans |-> !dat_o[4] && !dat_o[3])
    else $error("break or framing flag survived status read");
  AST_LSR_RSVD: assert property (lsr_ans |-> !dat_o[31:8] && !dat_o[2:0])
    else $error("status read shows bits outside this block");
  AST_RFE_OFF: assert property (lsr_ans ##0 !fcr0 |-> !dat_o[7])
    else $error("fifo error summary shown with fifo off");
  AST_IRQ_GATE: assert property (thre_irq_o |-> ier1 || $past(ier1))
    else $error("holding-empty interrupt while disabled");
  AST_IRQ_DROP: assert property (
    tx_wr_o && ier1 && !ier7 |-> ##[1:2] !thre_irq_o)
    else $error("holding-empty interrupt kept after a write");
endmodule // uart_lsf_asserts

bind uart_line_status_flags uart_lsf_asserts i_chk (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
  .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
  .sin_i(sin_i), .sir_in_i(sir_in_i), .tx_load_i(tx_load_i),
  .tx_shift_empty_i(tx_shift_empty_i), .tx_data_o(tx_data_o),
  .tx_wr_o(tx_wr_o), .thre_irq_o(thre_irq_o));

// [uart_line_model.sv]
`timescale 1ns/1ps
module uart_line_model (
  input  wire clk_i,
  input  wire rst_i,
  input  wire ir_i,
  input  wire hold_i,
  input  wire tx_wr_i,
  output reg  sin_o = 1'b1,
  output reg  sir_o = 1'b1,
  output reg  tx_load_o = 1'b0,
  output reg  tx_shift_empty_o = 1'b1
);
  integer pend = 0;
  integer busy = 0;

  // one bit of 16 clocks; infrared zero is a short low pulse
  task bitx(input logic b);
    if (ir_i) begin
      sir_o <= b;
      repeat (3) @(posedge clk_i);
      sir_o <= 1'b1;
      repeat (13) @(posedge clk_i);
    end else begin
      sin_o <= b;
      repeat (16) @(posedge clk_i);
    end
  endtask

  // 8 data bits lsb first, chosen stop level, then two idle bits
  task frame(input logic [7:0] d, input logic stop);
    integer i;
    bitx(1'b0);
    for (i = 0; i < 8; i = i + 1) bitx(d[i]);
    bitx(stop);
    bitx(1'b1);
    bitx(1'b1);
  endtask

  // line held (or pulsed) low for n bit times
  task brk(input integer n);
    repeat (n) bitx(1'b0);
    bitx(1'b1);
    bitx(1'b1);
  endtask

  ////////////////////////////////////////////////////////////////////
  // far-end shifter: stalls on hold_i, otherwise a random shift time
  always @(posedge clk_i) begin
    tx_load_o <= 1'b0;
    if (rst_i) begin
      pend = 0;
      busy = 0;
    end else begin
      if (tx_wr_i) pend = pend + 1;
      if (busy > 0) busy = busy - 1;
      else if (pend > 0 && !hold_i) begin
        pend = pend - 1;
        busy = 8 + $urandom % 30;
        tx_load_o <= 1'b1;
      end
    end
    tx_shift_empty_o <= (busy == 0);
  end
endmodule // uart_line_model

// [uart_line_status_flags_tb.sv]
`timescale 1ns/1ps
`include "uart_lsf_defs.vh"
module uart_line_status_flags_tb;
  reg          clk_i = 1'b0;
  reg          rst_i = 1'b1;
  reg          cyc_i = 1'b0;
  reg          stb_i = 1'b0;
  reg          we_i = 1'b0;
  reg  [7:0]   adr_i = 8'h00;
  reg  [3:0]   sel_i = 4'h0;
  reg  [31:0]  dat_i = 32'h0;
  reg          ir = 1'b0;
  reg          hold = 1'b0;
  wire [31:0]  dat_o;
  wire [7:0]   tx_data_o;
  wire         ack_o, sin, sir, tx_load, tx_shift_empty, tx_wr_o, thre_irq_o;
  integer      err_count = 0;
  integer      checks_done = 0;
  integer      i, md;
  logic [31:0] qe[$], qm[$], txq[$];

  uart_line_status_flags i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .sin_i(sin), .sir_in_i(sir),
    .tx_load_i(tx_load), .tx_shift_empty_i(tx_shift_empty),
    .tx_data_o(tx_data_o), .tx_wr_o(tx_wr_o), .thre_irq_o(thre_irq_o));
  uart_line_model i_line (.clk_i(clk_i), .rst_i(rst_i), .ir_i(ir),
    .hold_i(hold), .tx_wr_i(tx_wr_o), .sin_o(sin), .sir_o(sir),
    .tx_load_o(tx_load), .tx_shift_empty_o(tx_shift_empty));

  initial begin
    forever #25 clk_i = ~clk_i;
  end

  ////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] g, input logic [31:0] e, input logic [31:0] m);
    checks_done = checks_done + 1;
    if ((g & m) !== (e & m)) begin
      err_count = err_count + 1;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task test_done;
    if (err_count == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // one classic cycle; expectation noted first, mask 0 for writes
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d,
          input logic [31:0] e, input logic [31:0] m);
    qe.push_back(e);
    qm.push_back(m);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= 4'h1;
    @(posedge clk_i);
    while (ack_o !== 1'b1) @(posedge clk_i);
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task line_status(input logic [31:0] e);
    wb(1'b0, `ADR_LINE_STATUS, 32'h0, e, 32'hffffffff);
  endtask

  task rxd(input logic [7:0] e);
    wb(1'b0, `ADR_RX_DATA, 32'h0, {24'h0, e}, 32'hff);
  endtask

  // random byte to transmit; dropped writes leave no expectation
  task tx(input logic acc);
    logic [7:0] d;
    d = 8'($urandom);
    if (acc) txq.push_back({24'h0, d});
    wb(1'b1, `ADR_RX_DATA, {24'h0, d}, 32'h0, 32'h0);
  endtask

  task irq(input logic e);
    chk({31'h0, thre_irq_o}, {31'h0, e}, 32'h1);
  endtask

  // bounded wait until the far-end shifter has taken everything
  task drain;
    integer k;
    for (k = 0; k < 4000; k = k + 1) begin
      // look between edges: the model updates its counts on the edge
      @(negedge clk_i);
      if (i_line.pend == 0 && tx_shift_empty === 1'b1) k = 4000;
    end
    repeat (3) @(posedge clk_i);
  endtask

  // results are compared in order as they appear at the outputs
  always @(posedge clk_i) begin
    if (ack_o === 1'b1) chk(dat_o, qe.pop_front(), qm.pop_front());
    if (tx_wr_o === 1'b1) chk({24'h0, tx_data_o}, txq.pop_front(), 32'hff);
  end

  initial begin
    #1000000;
    err_count = err_count + 1;
    test_done;
  end

  ////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(27559));
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    line_status(32'h60);
    irq(1'b0);
    wb(1'b0, 8'h1c, 32'h0, 32'h0, 32'hffffffff);
    wb(1'b1, 8'h1c, 32'hff, 32'h0, 32'h0);
    // break in plain and infrared mode, fifo off
    for (md = 0; md < 2; md = md + 1) begin
      ir <= md[0];
      wb(1'b1, `ADR_LINE_CONTROL, md ? 32'h43 : 32'h03, 32'h0, 32'h0);
      i_line.brk(14);
      line_status(32'h78);
      line_status(32'h60);
      rxd(8'h00);
      wb(1'b0, `ADR_RX_LEVEL, 32'h0, 32'h0, 32'h1f);
    end
    ir <= 1'b0;
    wb(1'b1, `ADR_LINE_CONTROL, 32'h03, 32'h0, 32'h0);
    // fifo on: good char, break char, framing-only char
    wb(1'b1, `ADR_FIFO_CONTROL, 32'h01, 32'h0, 32'h0);
    i_line.frame(8'h3c, 1'b1);
    i_line.brk(14);
    i_line.frame(8'h80, 1'b0);
    line_status(32'he0);
    rxd(8'h3c);
    line_status(32'hf8);
    line_status(32'he0);
    rxd(8'h00);
    line_status(32'he8);
    line_status(32'h60);
    rxd(8'h80);
    wb(1'b0, `ADR_RX_LEVEL, 32'h0, 32'h0, 32'h1f);
    // transmit path, fifo on, far end stalled then released
    wb(1'b1, `ADR_IRQ_ENABLE, 32'h02, 32'h0, 32'h0);
    hold <= 1'b1;
    tx(1'b1);
    tx(1'b1);
    line_status(32'h00);
    irq(1'b0);
    hold <= 1'b0;
    drain;
    line_status(32'h60);
    irq(1'b1);
    // programmable mode: flag means full, threshold 4 drives the irq
    wb(1'b1, `ADR_IRQ_ENABLE, 32'h82, 32'h0, 32'h0);
    wb(1'b1, `ADR_FIFO_CONTROL, 32'h21, 32'h0, 32'h0);
    hold <= 1'b1;
    for (i = 0; i < 17; i = i + 1) tx(i < 16);
    line_status(32'h20);
    irq(1'b0);
    hold <= 1'b0;
    drain;
    line_status(32'h40);
    irq(1'b1);
    // fifo off: single holding place
    wb(1'b1, `ADR_IRQ_ENABLE, 32'h02, 32'h0, 32'h0);
    wb(1'b1, `ADR_FIFO_CONTROL, 32'h00, 32'h0, 32'h0);
    tx(1'b1);
    line_status(32'h20);
    drain;
    hold <= 1'b1;
    tx(1'b1);
    tx(1'b0);
    line_status(32'h00);
    irq(1'b0);
    hold <= 1'b0;
    drain;
    line_status(32'h60);
    irq(1'b1);
    chk(32'(txq.size()), 32'h0, 32'hffffffff);
    test_done;
  end
endmodule // uart_line_status_flags_tb
